// ### logic/uls_pkg.sv
// Shared constants and types of the UART line status flag block.
// Assumes one core clock; every user of it imports uls_pkg::*.
package uls_pkg;

    // ------------------------------------------------------------------
    // Status byte bit positions
    // ------------------------------------------------------------------
    localparam int LS_RX_READY  = 0;
    localparam int LS_OVERRUN   = 1;
    localparam int LS_PARITY    = 2;
    localparam int LS_FRAMING   = 3;
    localparam int LS_BREAK     = 4;
    localparam int LS_THR_EMPTY = 5;
    localparam int LS_TX_EMPTY  = 6;
    localparam int LS_FIFO_ERR  = 7;

    // ------------------------------------------------------------------
    // Receive entry layout: data byte plus three error flags
    // ------------------------------------------------------------------
    localparam int ULS_DATA_W   = 8;
    localparam int ULS_ENTRY_W  = 11;
    localparam int ENT_PE       = 8;
    localparam int ENT_FE       = 9;
    localparam int ENT_BI       = 10;

    // ------------------------------------------------------------------
    // Reset values and fixed contents
    // ------------------------------------------------------------------
    localparam logic [7:0]  LS_RESET_VAL   = 8'h60;
    localparam logic [7:0]  ULS_BREAK_DATA = 8'h00;
    localparam logic [10:0] ULS_ENTRY_RST  = 11'h000;
    localparam int          ULS_HOLD_DEPTH = 1;

    typedef logic [ULS_ENTRY_W-1:0] uls_entry_t;

    // Break tracking states
    typedef enum logic [1:0]
    {
        BRK_IDLE   = 2'b01,
        BRK_ACTIVE = 2'b10
    } uls_brk_e;

endpackage : uls_pkg

// ### logic/uls_fifo_if.sv
// Port bundle between the receive FIFO control and its storage array.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
`default_nettype none
interface uls_fifo_if
#(
    parameter int AW = 4
);
    import uls_pkg::*;

    logic            wr_en;
    logic [AW-1:0]   wr_addr;
    uls_entry_t      wr_data;
    logic [AW-1:0]   rd_addr;
    uls_entry_t      rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface : uls_fifo_if
`default_nettype wire

// ### logic/uls_rx_mem.sv
// Storage array of the receive FIFO with a registered read port.
// Assumes the controller presents the address of the next head entry.
`timescale 1ns/10ps
`default_nettype none
module uls_rx_mem
    import uls_pkg::*;
#(
    parameter int DEPTH = 16
)
(
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    input  wire logic   ce_i,
    uls_fifo_if.mem     bus
);

    uls_entry_t mem [DEPTH];

    // Write port; no reset so the array maps onto plain RAM
    always_ff @(posedge clk_i)
    begin
        if (ce_i && bus.wr_en)
        begin
            mem[bus.wr_addr] <= bus.wr_data;
        end
    end

    // Registered read; bypass keeps a fresh head visible at once
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            bus.rd_data <= ULS_ENTRY_RST;
        end
        else if (ce_i)
        begin
            if (bus.wr_en && (bus.wr_addr == bus.rd_addr))
            begin
                bus.rd_data <= bus.wr_data;
            end
            else
            begin
                bus.rd_data <= mem[bus.rd_addr];
            end
        end
    end

endmodule // uls_rx_mem
`default_nettype wire

// ### logic/uls_line_status.sv
// Line status flag logic: receive FIFO with per-entry error flags,
// transmit empty tracking and the read-only status byte.
// Assumes receiver, transmitter and host strobes are synchronous to CLK_I.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// [R1] In FIFO mode bit 7 is high while any stored receive entry carries an error flag.
// [R2] Bit 7 drops by itself once no stored entry carries an error flag.
// [R3] Outside FIFO mode bit 6 is high when holding and shifter are empty.
// [R4] In FIFO mode bit 6 is high only when tx FIFO and shifter are empty.
// [R5] Outside FIFO mode bit 5 sets on load to the shifter, clears on write.
// [R6] In FIFO mode bit 5 follows an empty tx FIFO; a write clears it only through TX_FIFO_EMPTY_I.
// [R7] The transmit interrupt is high while bit 5 and its enable are set.
// [R8] Bit 4 is set when the line stayed low for a whole frame.
// [R9] In FIFO mode each break condition stores one break entry, or none if the FIFO is full when it begins.
// [R10] Bit 3 is set when a received character had no valid stop bit.
// [R11] In FIFO mode bit 3 belongs to the entry at the head of the FIFO.
// [R12] After reset bits 7, 4 and 3 read zero.
// [R13] Bit 2 shows a parity error, for the head entry in FIFO mode.
// [R14] A character ending while the FIFO is full sets bit 1 and is dropped.
// [R15] Bit 0 is high while at least one received character is waiting.
// [R16] Parity, framing and break flags are stored with every entry.
// [R17] A break is stored as a zero data byte tagged with the break flag.
module uls_line_status
    import uls_pkg::*;
#(
    parameter int DEPTH = 16
)
(
    input  wire logic                    CLK_I,
    input  wire logic                    RESET_N_I,
    input  wire logic                    CE_I,
    input  wire logic                    FIFO_MODE_I,
    input  wire logic                    THR_IE_I,
    input  wire logic                    RX_CHAR_VALID_I,
    input  wire logic [uls_pkg::ULS_DATA_W-1:0] RX_DATA_I,
    input  wire logic                    RX_PARITY_ERR_I,
    input  wire logic                    RX_FRAME_ERR_I,
    input  wire logic                    RX_BREAK_I,
    input  wire logic                    RD_RX_I,
    input  wire logic                    RD_STATUS_I,
    input  wire logic                    WR_TX_I,
    input  wire logic                    TX_LOAD_I,
    input  wire logic                    TX_FIFO_EMPTY_I,
    input  wire logic                    TX_SHIFT_BUSY_I,
    output logic [uls_pkg::ULS_DATA_W-1:0] RX_DATA_O,
    output logic [7:0]                   LINE_STATUS_O,
    output logic                         TX_IRQ_O
);
    import uls_pkg::*;

    localparam int AW    = $clog2(DEPTH);
    localparam int CNT_W = AW + 1;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Pointers wrap naturally, so the depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 2");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    uls_brk_e           brk_st;
    logic               fifo_mode_q;
    logic [AW-1:0]      wptr;
    logic [AW-1:0]      rptr;
    logic [AW-1:0]      next_rptr;
    logic [CNT_W-1:0]   rx_count;
    logic [CNT_W-1:0]   err_cnt;
    logic [CNT_W-1:0]   capacity;
    logic               rx_full;
    logic               push_brk;
    logic               push_req;
    logic               push;
    logic               pop;
    logic               push_err;
    logic               head_err;
    logic               mode_flip;
    logic               overrun;
    logic               thr_full;
    logic               next_thr_full;
    logic               next_thr_empty;
    logic [7:0]         next_ls;
    logic [7:0]         line_status;
    logic               tx_irq;
    uls_entry_t         push_entry;
    uls_entry_t         head;

    uls_fifo_if #(.AW(AW)) fifo_bus ();

    // ------------------------------------------------------------------
    // Receive storage
    // ------------------------------------------------------------------
    uls_rx_mem #(.DEPTH(DEPTH)) u_rx_mem
    (
        .clk_i   (CLK_I),
        .rst_n_i (RESET_N_I),
        .ce_i    (CE_I),
        .bus     (fifo_bus.mem)
    );

    assign head = fifo_bus.rd_data;

    // ------------------------------------------------------------------
    // Push and pop decisions
    // ------------------------------------------------------------------
    // Holding register is a one-deep FIFO outside FIFO mode
    assign capacity  = fifo_mode_q ? CNT_W'(DEPTH) : CNT_W'(ULS_HOLD_DEPTH);
    assign rx_full   = (rx_count >= capacity);
    assign mode_flip = (FIFO_MODE_I != fifo_mode_q);
    // Only the first frame of a low line becomes an entry
    assign push_brk  = RX_BREAK_I && (brk_st == BRK_IDLE);        // R8 R9
    assign push_req  = push_brk
                     || (RX_CHAR_VALID_I && !RX_BREAK_I
                         && (brk_st == BRK_IDLE));
    assign push      = push_req && !rx_full;                      // R14
    assign pop       = RD_RX_I && (rx_count != '0);
    assign next_rptr = pop ? rptr + AW'(1) : rptr;
    assign head_err  = head[ENT_PE] || head[ENT_FE] || head[ENT_BI];

    // Entry built from receiver flags, or a tagged zero byte for a break
    always_comb
    begin
        if (push_brk)
        begin
            push_entry = {1'b1, 1'b0, 1'b0, ULS_BREAK_DATA};      // R17
        end
        else
        begin
            push_entry = {1'b0, RX_FRAME_ERR_I, RX_PARITY_ERR_I,
                          RX_DATA_I};                             // R16
        end
    end

    assign push_err          = push_entry[ENT_PE] || push_entry[ENT_FE]
                             || push_entry[ENT_BI];
    assign fifo_bus.wr_en    = push && CE_I && !mode_flip;
    assign fifo_bus.wr_addr  = wptr;
    assign fifo_bus.wr_data  = push_entry;
    assign fifo_bus.rd_addr  = next_rptr;

    // ------------------------------------------------------------------
    // Break tracking
    // ------------------------------------------------------------------
    // Stays active until the line returns high, however long it is low
    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            brk_st <= BRK_IDLE;
        end
        else if (CE_I)
        begin
            case (brk_st)
                BRK_IDLE:   if (RX_BREAK_I) brk_st <= BRK_ACTIVE; // R9
                BRK_ACTIVE: if (!RX_BREAK_I) brk_st <= BRK_IDLE;
                default:    brk_st <= BRK_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pointers, occupancy and error count
    // ------------------------------------------------------------------
    // A mode change flushes the receive side so stale entries vanish
    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            fifo_mode_q <= 1'b0;
            wptr        <= '0;
            rptr        <= '0;
            rx_count    <= '0;
            err_cnt     <= '0;
        end
        else if (CE_I)
        begin
            fifo_mode_q <= FIFO_MODE_I;
            if (mode_flip)
            begin
                wptr     <= '0;
                rptr     <= '0;
                rx_count <= '0;
                err_cnt  <= '0;
            end
            else
            begin
                rptr <= next_rptr;
                if (push)
                begin
                    wptr <= wptr + AW'(1);
                end
                rx_count <= rx_count + CNT_W'(push) - CNT_W'(pop);
                // Count of stored entries that carry any flag
                err_cnt  <= err_cnt + CNT_W'(push && push_err)
                          - CNT_W'(pop && head_err);             // R1 R2
            end
        end
    end

    // ------------------------------------------------------------------
    // Overrun flag
    // ------------------------------------------------------------------
    // Set wins over the clear by a status read in the same cycle
    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            overrun <= 1'b0;
        end
        else if (CE_I)
        begin
            if (push_req && rx_full)
            begin
                overrun <= 1'b1;                                  // R14
            end
            else if (RD_STATUS_I)
            begin
                overrun <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit holding register occupancy
    // ------------------------------------------------------------------
    // A host write in the same cycle as a transfer leaves it full
    always_comb
    begin
        if (fifo_mode_q)
        begin
            next_thr_full  = 1'b0;
            next_thr_empty = TX_FIFO_EMPTY_I;                     // R6
        end
        else
        begin
            next_thr_full  = WR_TX_I || (thr_full && !TX_LOAD_I); // R5
            next_thr_empty = !next_thr_full;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            thr_full <= 1'b0;
        end
        else if (CE_I)
        begin
            thr_full <= next_thr_full;
        end
    end

    // ------------------------------------------------------------------
    // Status byte
    // ------------------------------------------------------------------
    // Receive bits lag state by one edge; transmit bits use next state
    always_comb
    begin
        next_ls               = '0;
        next_ls[LS_RX_READY]  = (rx_count != '0);                 // R15
        next_ls[LS_OVERRUN]   = overrun;
        next_ls[LS_PARITY]    = (rx_count != '0) && head[ENT_PE]; // R13
        next_ls[LS_FRAMING]   = (rx_count != '0) && head[ENT_FE]; // R10 R11
        next_ls[LS_BREAK]     = (rx_count != '0) && head[ENT_BI]; // R8
        next_ls[LS_THR_EMPTY] = next_thr_empty;                   // R5 R6
        next_ls[LS_TX_EMPTY]  = next_thr_empty && !TX_SHIFT_BUSY_I; // R3 R4
        next_ls[LS_FIFO_ERR]  = fifo_mode_q && (err_cnt != '0);   // R1 R2
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            line_status <= LS_RESET_VAL;                          // R12
            tx_irq      <= 1'b0;
        end
        else if (CE_I)
        begin
            line_status <= next_ls;
            tx_irq      <= next_thr_empty && THR_IE_I;            // R7
        end
    end

    assign LINE_STATUS_O = line_status;
    assign TX_IRQ_O      = tx_irq;
    assign RX_DATA_O     = head[ULS_DATA_W-1:0];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    sequence s_brk_taken;
        CE_I && push_brk && !mode_flip;
    endsequence

    sequence s_overrun_hit;
        CE_I && push_req && rx_full && !mode_flip;
    endsequence

    a_err_summary: // R1 R2
    assert property (CE_I |=> line_status[LS_FIFO_ERR]
                     == ($past(fifo_mode_q) && ($past(err_cnt) != '0)))
        else $error("error summary does not track stored flags");

    a_tx_empty: // R3 R4
    assert property (CE_I |=> line_status[LS_TX_EMPTY]
                     == (line_status[LS_THR_EMPTY]
                         && !$past(TX_SHIFT_BUSY_I)))
        else $error("transmitter empty bit wrong");

    a_thr_write_clr: // R5
    assert property (CE_I && !fifo_mode_q && WR_TX_I
                     |=> !line_status[LS_THR_EMPTY])
        else $error("holding empty bit not cleared by write");

    a_thr_fifo: // R6
    assert property (CE_I && fifo_mode_q
                     |=> line_status[LS_THR_EMPTY] == $past(TX_FIFO_EMPTY_I))
        else $error("holding empty bit ignores fifo empty");

    a_tx_irq: // R7
    assert property (CE_I |=> TX_IRQ_O
                     == (line_status[LS_THR_EMPTY] && $past(THR_IE_I)))
        else $error("transmit interrupt mismatch");

    a_one_break: // R9
    assert property (s_brk_taken |=> !push_brk
                     ##1 (!push_brk || !$past(RX_BREAK_I)))
        else $error("second break entry for one condition");

    a_break_stored: // R8 R17
    assert property ((s_brk_taken and !rx_full)
                     |=> rx_count == $past(rx_count) + CNT_W'(1)
                         - CNT_W'($past(pop)))
        else $error("break entry not stored");

    a_head_frame: // R10 R11
    assert property (CE_I |=> line_status[LS_FRAMING]
                     == (($past(rx_count) != '0) && $past(head[ENT_FE])))
        else $error("framing bit not from head entry");

    a_head_parity: // R13
    assert property (CE_I |=> line_status[LS_PARITY]
                     == (($past(rx_count) != '0) && $past(head[ENT_PE])))
        else $error("parity bit not from head entry");

    a_overrun_set: // R14
    assert property (s_overrun_hit |=> overrun
                     && rx_count == $past(rx_count) - CNT_W'($past(pop))
                     ##1 (!$past(CE_I) || line_status[LS_OVERRUN]))
        else $error("overrun not flagged or fifo changed");

    a_rx_ready: // R15
    assert property (CE_I |=> line_status[LS_RX_READY]
                     == ($past(rx_count) != '0))
        else $error("data ready bit wrong");

    a_reset_clear: // R12
    assert property (disable iff (1'b0) !RESET_N_I |=> (line_status[7] == 1'b0)
                     && (line_status[4:3] == 2'b00))
        else $error("error bits not zero after reset");

endmodule // uls_line_status
`default_nettype wire

// ### verif/uls_tx_model.sv
// Transmit side stand-in: queues written bytes and shifts them out.
// Assumes the bench clock and the block's synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module uls_tx_model
#(
    parameter int LOAD_DLY  = 8,
    parameter int SHIFT_CYC = 8
)
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic wr_i,
    output logic      load_o,
    output logic      fifo_empty_o,
    output logic      busy_o
);
    logic [7:0] pend;
    logic [7:0] gap;
    logic [7:0] busy_cnt;
    logic       go;

    // ------------------------------------------------------------------
    // Byte queue and shifter
    // ------------------------------------------------------------------
    // A write restarts the start delay, so bursts stay queued a while
    assign go = (pend != 8'h00) && (gap == 8'h00) && (busy_cnt == 8'h00)
                && !wr_i;

    // Counters move only on the clock, so the block sees settled levels
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pend     <= 8'h00;
            gap      <= 8'h00;
            busy_cnt <= 8'h00;
            load_o   <= 1'b0;
        end
        else
        begin
            load_o   <= go;
            gap      <= wr_i ? 8'(LOAD_DLY) : gap - {7'h00, gap != 8'h00};
            busy_cnt <= go ? 8'(SHIFT_CYC)
                           : busy_cnt - {7'h00, busy_cnt != 8'h00};
            pend     <= pend + {7'h00, wr_i} - {7'h00, go};
        end
    end

    // Levels seen by the block
    assign fifo_empty_o = (pend == 8'h00);
    assign busy_o       = (busy_cnt != 8'h00);
endmodule // uls_tx_model
`default_nettype wire

// ### verif/tb_uls_line_status.sv
// Self-checking bench of the line status block with a transmit model.
// Assumes uls_pkg and the design files are compiled beforehand.
`timescale 1ns/10ps
`default_nettype none
module tb_uls_line_status;
    import uls_pkg::*;

    localparam int DEPTH = 4;

    logic       clk = 1'b0;
    logic       reset_n;
    logic       ce;
    logic       fifo_mode;
    logic       ie;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       rx_pe;
    logic       rx_fe;
    logic       rx_brk;
    logic       rd_rx;
    logic       rd_st;
    logic       wr_tx;
    logic       tx_load;
    logic       tx_empty;
    logic       tx_busy;
    logic [7:0] dout;
    logic [7:0] status;
    logic       irq;
    logic [7:0] lfsr;
    logic [8:0] st_q[$];
    logic [7:0] rx_q[$];
    logic [7:0] held[$];
    int         n_fail = 0;
    int         cmp_count = 0;
    int         cycles = 0;

    // ------------------------------------------------------------------
    // Clock, block and transmit model
    // ------------------------------------------------------------------
    always #5 clk = ~clk;

    uls_line_status #(.DEPTH(DEPTH)) dut
    (
        .CLK_I(clk), .RESET_N_I(reset_n), .CE_I(ce),
        .FIFO_MODE_I(fifo_mode), .THR_IE_I(ie),
        .RX_CHAR_VALID_I(rx_valid), .RX_DATA_I(rx_data),
        .RX_PARITY_ERR_I(rx_pe), .RX_FRAME_ERR_I(rx_fe),
        .RX_BREAK_I(rx_brk), .RD_RX_I(rd_rx), .RD_STATUS_I(rd_st),
        .WR_TX_I(wr_tx), .TX_LOAD_I(tx_load),
        .TX_FIFO_EMPTY_I(tx_empty), .TX_SHIFT_BUSY_I(tx_busy),
        .RX_DATA_O(dout), .LINE_STATUS_O(status), .TX_IRQ_O(irq)
    );

    uls_tx_model txm
    (
        .clk_i(clk), .rst_n_i(reset_n), .wr_i(wr_tx),
        .load_o(tx_load), .fifo_empty_o(tx_empty), .busy_o(tx_busy)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // Inputs move 1 ns after the edge so sampling never races
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Status read: strobes drop first, the byte gets time to settle
    task automatic expect_st(input logic [7:0] s);
        {rx_valid, rd_rx, wr_tx} = 3'b000;
        cyc(3);
        st_q.push_back({ie & s[LS_THR_EMPTY], s});
        rd_st = 1'b1;
        cyc(1);
        rd_st = 1'b0;
    endtask

    // Strobe stays up on return so back-to-back calls never glitch it
    task automatic push(input logic keep, input logic pe, input logic fe);
        lfsr = lfsr_next(lfsr);
        {rx_valid, rx_data, rx_pe, rx_fe} = {1'b1, lfsr, pe, fe};
        if (keep)
            held.push_back(lfsr);
        cyc(1);
    endtask

    task automatic pop();
        rx_q.push_back(held.pop_front());
        rd_rx = 1'b1;
        cyc(1);
    endtask

    task automatic done(input string name);
        $display("Test %s finished at %0t", name, $time);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Monitor and watchdog
    // ------------------------------------------------------------------
    // Values read here are those registered before this edge
    always @(posedge clk)
    begin
        if (rd_st === 1'b1 && st_q.size() > 0)
            check({irq, status}, st_q.pop_front());
        if (rd_rx === 1'b1 && rx_q.size() > 0)
            check({1'b0, dout}, {1'b0, rx_q.pop_front()});
    end

    // Whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            $display("Error at %0t: run did not finish", $time);
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {reset_n, fifo_mode, rx_valid, rx_data, rx_pe, rx_fe} = '0;
        {rx_brk, rd_rx, rd_st, wr_tx} = '0;
        {ce, ie} = 2'b11;
        lfsr = 8'h18;
        cyc(20);
        reset_n = 1'b1;
        expect_st(8'h60);
        ie = 1'b0;
        expect_st(8'h60);
        done("reset");

        // Holding register empties only when the shifter takes it
        ie = lfsr[0];
        wr_tx = 1'b1;
        cyc(1);
        expect_st(8'h00);
        cyc(6);
        expect_st(8'h20);
        cyc(10);
        expect_st(8'h60);
        done("tx_holding");

        // One-deep receive path: frozen clock, overrun, errors
        ce = 1'b0;
        push(1'b0, 1'b0, 1'b0);
        rx_valid = 1'b0;
        ce = 1'b1;
        expect_st(8'h60);
        push(1'b1, 1'b1, 1'b0);
        push(1'b0, 1'b0, 1'b1);
        expect_st(8'h67);
        expect_st(8'h65);
        pop();
        expect_st(8'h60);
        push(1'b1, 1'b0, 1'b1);
        expect_st(8'h69);
        pop();
        expect_st(8'h60);
        done("rx_holding");

        // FIFO transmit: empty flag waits for the whole queue
        fifo_mode = 1'b1;
        ie = 1'b1;
        cyc(3);
        wr_tx = 1'b1;
        cyc(2);
        expect_st(8'h00);
        cyc(6);
        expect_st(8'h00);
        cyc(30);
        expect_st(8'h60);
        done("tx_fifo");

        // FIFO receive: fill past full, walk the head flags out
        for (int k = 0; k < DEPTH + 1; k++)
            push(k < DEPTH, k == 2, k == 1);
        expect_st(8'he3);
        expect_st(8'he1);
        pop();
        expect_st(8'he9);
        pop();
        expect_st(8'he5);
        pop();
        expect_st(8'h61);
        pop();
        expect_st(8'h60);
        done("rx_fifo");

        // Two breaks, a long one with a stray character inside
        rx_brk = 1'b1;
        cyc(1);
        rx_valid = 1'b1;
        cyc(1);
        rx_valid = 1'b0;
        cyc(6);
        rx_brk = 1'b0;
        cyc(2);
        rx_brk = 1'b1;
        cyc(3);
        rx_brk = 1'b0;
        held.push_back(8'h00);
        held.push_back(8'h00);
        expect_st(8'hf1);
        pop();
        expect_st(8'hf1);
        pop();
        expect_st(8'h60);
        done("break");

        report_and_stop();
    end
endmodule // tb_uls_line_status
`default_nettype wire
